// ===== src/excl_monitor_defines.svh
// Constants for the local exclusive-access monitor
`ifndef EXCL_MONITOR_DEFINES_SVH
`define EXCL_MONITOR_DEFINES_SVH
`define ADDR_W          32
`define DATA_W          32
`define TAG_LSB         5
`define STATUS_OK       1'h0
`define STATUS_FAIL     1'h1
`define REG_IDX_W       4
`endif

// ===== src/excl_monitor_pkg.sv
// Types for the local exclusive-access monitor
`include "excl_monitor_defines.svh"
package excl_monitor_pkg;
    typedef enum logic [1:0] {
        OP_LOAD_EXCL,
        OP_STORE_EXCL,
        OP_STORE,
        OP_CLEAR_EXCL
    } mon_op_t;

    typedef enum logic [1:0] {
        SIZE_BYTE,
        SIZE_HALF,
        SIZE_WORD
    } acc_size_t;

    typedef enum {
        MON_OPEN,
        MON_EXCL
    } mon_state_t;

    // Request from the load/store pipeline
    typedef struct packed {
        logic                    valid;
        mon_op_t                 op;
        acc_size_t               size;
        logic                    shareable;
        logic [`ADDR_W-1:0]      addr;
        logic [`DATA_W-1:0]      wdata;
        logic [`REG_IDX_W-1:0]   dest;
    } lsu_req_t;

    // Access to the memory path
    typedef struct packed {
        logic                    valid;
        logic                    write;
        acc_size_t               size;
        logic [`ADDR_W-1:0]      addr;
        logic [`DATA_W-1:0]      wdata;
    } mem_req_t;

    // Status write-back for a store-exclusive
    typedef struct packed {
        logic                    valid;
        logic [`REG_IDX_W-1:0]   dest;
        logic                    status;
    } status_wb_t;
endpackage

// ===== src/excl_monitor.sv
// Local exclusive-access monitor between load/store pipeline and memory path
// Notes on behaviour
// - Exclusive load always reads and returns data
// - Exclusive load tags address, enters exclusive
// - Matching exclusive store writes, status 0, opens
// - Mismatching exclusive store: chosen policy, then open
// - Open state exclusive store: no write, status 1
// - Status goes to instruction's own destination
// - Repeat exclusive load retags, stays exclusive
// - Plain store elsewhere writes, state unchanged
// - Plain store to tag writes; chosen policy, default opens
// - Compare only address bits 31 down to 5
// - Optional addressless mode matches every store
// - Other processors' accesses are ignored
// - Only byte, halfword, word exclusives handled
// - Monitor applies only to non-shareable memory
`timescale 1ns/1ns
`include "excl_monitor_defines.svh"
module excl_monitor #(
    parameter bit NO_ADDR_TAG       = 1'b0,
    parameter bit MISMATCH_WRITES   = 1'b0,
    parameter bit STORE_CLEARS_TAG  = 1'b1
) (
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    input  wire excl_monitor_pkg::lsu_req_t    lsu_req,
    output logic                               lsu_ready,
    output excl_monitor_pkg::mem_req_t         mem_req,
    input  wire logic                          mem_ready,
    output excl_monitor_pkg::status_wb_t       status_wb,
    output logic                               excl_state
);

    localparam int TAG_W = `ADDR_W - `TAG_LSB;

    logic                          rst_meta_r;
    logic                          rst_sync_r;
    excl_monitor_pkg::mon_state_t  state_r;
    excl_monitor_pkg::mon_state_t  state_nxt;
    logic [TAG_W-1:0]              tag_r;
    logic [TAG_W-1:0]              tag_nxt;
    excl_monitor_pkg::mem_req_t    mem_r;
    excl_monitor_pkg::mem_req_t    mem_nxt;
    excl_monitor_pkg::status_wb_t  wb_r;
    excl_monitor_pkg::status_wb_t  wb_nxt;
    logic                          take;
    logic                          hit;
    logic                          pass;

    // Granule compare on the upper address bits only
    function automatic logic tag_hit(input logic [`ADDR_W-1:0] a, input logic [TAG_W-1:0] t);
        tag_hit = NO_ADDR_TAG ? 1'b1 : (a[`ADDR_W-1:`TAG_LSB] == t);
    endfunction

    // Reset release through two flops
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // One request in flight; stall while memory holds the last one
    assign lsu_ready  = !mem_r.valid || mem_ready;
    assign take       = lsu_req.valid && lsu_ready;
    assign hit        = tag_hit(lsu_req.addr, tag_r);
    assign mem_req    = mem_r;
    assign status_wb  = wb_r;
    assign excl_state = (state_r == excl_monitor_pkg::MON_EXCL);

    // Monitor decisions for each accepted operation
    always_comb
    begin
        state_nxt = state_r;
        tag_nxt   = tag_r;
        mem_nxt   = mem_r;
        wb_nxt    = '0;
        pass      = 1'b0;
        if (mem_r.valid && mem_ready)
            mem_nxt.valid = 1'b0;
        // Shareable accesses belong to the global monitor, not here
        if (take && !lsu_req.shareable)
        begin
            mem_nxt.size  = lsu_req.size;
            mem_nxt.addr  = lsu_req.addr;
            mem_nxt.wdata = lsu_req.wdata;
            case (lsu_req.op)
                excl_monitor_pkg::OP_LOAD_EXCL:
                begin
                    mem_nxt.valid = 1'b1;
                    mem_nxt.write = 1'b0;
                    tag_nxt       = lsu_req.addr[`ADDR_W-1:`TAG_LSB];
                    state_nxt     = excl_monitor_pkg::MON_EXCL;
                end
                excl_monitor_pkg::OP_STORE_EXCL:
                begin
                    if (state_r == excl_monitor_pkg::MON_EXCL)
                        pass = hit ? 1'b1 : MISMATCH_WRITES;
                    else
                        pass = 1'b0;
                    mem_nxt.valid  = pass;
                    mem_nxt.write  = 1'b1;
                    state_nxt      = excl_monitor_pkg::MON_OPEN;
                    wb_nxt.valid   = 1'b1;
                    wb_nxt.dest    = lsu_req.dest;
                    wb_nxt.status  = pass ? `STATUS_OK : `STATUS_FAIL;
                end
                excl_monitor_pkg::OP_STORE:
                begin
                    mem_nxt.valid = 1'b1;
                    mem_nxt.write = 1'b1;
                    if (hit && STORE_CLEARS_TAG)
                        state_nxt = excl_monitor_pkg::MON_OPEN;
                end
                default:
                begin
                    state_nxt = excl_monitor_pkg::MON_OPEN;
                    tag_nxt   = '0;
                end
            endcase
        end
        else if (take)
        begin
            // Shareable traffic other than clear-exclusive passes untouched to memory
            mem_nxt.valid = (lsu_req.op != excl_monitor_pkg::OP_CLEAR_EXCL);
            mem_nxt.write = (lsu_req.op != excl_monitor_pkg::OP_LOAD_EXCL);
            mem_nxt.size  = lsu_req.size;
            mem_nxt.addr  = lsu_req.addr;
            mem_nxt.wdata = lsu_req.wdata;
        end
    end

    // State registers
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= excl_monitor_pkg::MON_OPEN;
            tag_r   <= '0;
            mem_r   <= '0;
            wb_r    <= '0;
        end
        else if (!rst_sync_r)
        begin
            state_r <= excl_monitor_pkg::MON_OPEN;
            tag_r   <= '0;
            mem_r   <= '0;
            wb_r    <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            tag_r   <= tag_nxt;
            mem_r   <= mem_nxt;
            wb_r    <= wb_nxt;
        end
    end

endmodule

// ===== bench/excl_monitor_chk.sv
// Port assertions for the exclusive-access monitor
`timescale 1ns/1ns
module excl_monitor_chk (
    input wire logic                         mclk,
    input wire logic                         rst_n,
    input wire excl_monitor_pkg::lsu_req_t   lsu_req,
    input wire logic                         lsu_ready,
    input wire excl_monitor_pkg::mem_req_t   mem_req,
    input wire logic                         mem_ready,
    input wire excl_monitor_pkg::status_wb_t status_wb,
    input wire logic                         excl_state
);
    logic [31:5] tag_r;
    wire         tk   = lsu_req.valid && lsu_ready && !lsu_req.shareable;
    wire         ld   = tk && lsu_req.op == excl_monitor_pkg::OP_LOAD_EXCL;
    wire         sx   = tk && lsu_req.op == excl_monitor_pkg::OP_STORE_EXCL;
    wire         hit  = lsu_req.addr[31:5] == tag_r;
    wire         keep = excl_state && !hit;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Shadow granule, so matches are judged independently of the design
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n) tag_r <= '0;
        else if (ld) tag_r <= lsu_req.addr[31:5];
    sequence s_wr; mem_req.valid && mem_req.write; endsequence
    property p_load; ld |=> mem_req.valid && !mem_req.write && excl_state; endproperty
    property p_match; sx && excl_state && hit |=> s_wr ##0 (!status_wb.status && !excl_state); endproperty
    property p_miss; sx && keep |=> status_wb.status && !mem_req.valid && !excl_state; endproperty
    property p_open; sx && !excl_state |=> status_wb.status && !mem_req.valid && !excl_state; endproperty
    property p_dest; sx |=> status_wb.valid && status_wb.dest == $past(lsu_req.dest); endproperty
    property p_store; tk && lsu_req.op == excl_monitor_pkg::OP_STORE |=> s_wr ##0 excl_state == $past(keep); endproperty
    property p_clear; tk && lsu_req.op == excl_monitor_pkg::OP_CLEAR_EXCL |=> !excl_state && !mem_req.valid; endproperty
    property p_share; lsu_req.valid && lsu_ready && lsu_req.shareable |=> $stable(excl_state); endproperty
    a_load:  assert property (p_load) else $error("load exclusive");
    a_match: assert property (p_match) else $error("matching store");
    a_miss:  assert property (p_miss) else $error("mismatch store");
    a_open:  assert property (p_open) else $error("open store");
    a_dest:  assert property (p_dest) else $error("status dest");
    a_store: assert property (p_store) else $error("plain store");
    a_clear: assert property (p_clear) else $error("clear");
    a_share: assert property (p_share) else $error("shareable");
endmodule

// ===== bench/mem_model.sv
// Memory path: accepts promptly or after random stalls
`timescale 1ns/1ns
module mem_model (
    input wire logic                       mclk,
    input wire excl_monitor_pkg::mem_req_t mem_req,
    output logic                           mem_ready
);
    integer seed = 32'h51;
    initial mem_ready = 1'b0;
    // Stalls force the monitor to hold its request
    always @(posedge mclk)
        mem_ready <= #1 ($random(seed) % 4) != 0;
endmodule

// ===== bench/tb.sv
// Random and directed traffic through the exclusive monitor
`timescale 1ns/1ns
module tb;
    logic        mclk = 0, rst_n = 0, mem_ready, lsu_ready, es, ex = 0;
    logic [31:5] tg = '0;
    integer      seed = 32'h3619, err_total = 0, total_checks = 0, cyc = 0, i;
    excl_monitor_pkg::lsu_req_t   rq = '0;
    excl_monitor_pkg::mem_req_t   mq;
    excl_monitor_pkg::status_wb_t sw;
    excl_monitor dut (.mclk(mclk), .rst_n(rst_n), .lsu_req(rq), .lsu_ready(lsu_ready), .mem_req(mq),
        .mem_ready(mem_ready), .status_wb(sw), .excl_state(es));
    mem_model mem (.mclk(mclk), .mem_req(mq), .mem_ready(mem_ready));
    initial forever #5 mclk = ~mclk;
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Status expected from the shadow state
    function logic st_exp(input logic [31:0] a);
        return !(ex && a[31:5] == tg);
    endfunction
    // One request, held until taken; valid stays up for back-to-back use
    task op(input logic [1:0] o, input logic [31:0] a, input logic sh);
        logic s;
        s = st_exp(a);
        rq.valid = 1'b1;
        rq.op = excl_monitor_pkg::mon_op_t'(o);
        rq.shareable = sh;
        rq.addr = a;
        rq.wdata = $random(seed);
        rq.dest = 4'($random(seed));
        if (o == 2'h0)
            rq.size = excl_monitor_pkg::acc_size_t'({$random(seed)} % 3);
        #2;
        while (!lsu_ready)
        begin
            @(posedge mclk);
            #3;
        end
        @(posedge mclk);
        #1;
        if (!sh)
        begin
            chk(sw.valid, o == 2'h1, "status valid");
            if (o == 2'h1) chk(sw.status, s, "status");
            if (o == 2'h1) chk(sw.dest, rq.dest, "dest");
            chk(mq.valid, o != 2'h3 && !(o == 2'h1 && s), "mem valid");
            if (o != 2'h3 && !(o == 2'h1 && s)) chk(mq.addr, a, "mem addr");
            ex = o == 2'h0 || (o == 2'h2 && ex && s);
            if (o == 2'h0) tg = a[31:5];
        end
        chk(es, ex, "state");
    endtask
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc > 20000)
        begin
            err_total++;
            print_verdict;
        end
    end
    initial
    begin
        repeat (20) @(posedge mclk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge mclk);
        #1 chk(es, 1'b0, "reset");
        op(2'h1, 32'h40, 1'b0);
        op(2'h0, 32'h40, 1'b0);
        op(2'h0, 32'h8000_0020, 1'b0);
        op(2'h1, 32'h8000_003c, 1'b0);
        op(2'h0, 32'h40, 1'b0);
        op(2'h1, 32'h8000_0000, 1'b0);
        op(2'h0, 32'h40, 1'b0);
        op(2'h2, 32'h8000_0000, 1'b0);
        op(2'h2, 32'h44, 1'b0);
        op(2'h3, 32'h0, 1'b0);
        for (i = 0; i < 400; i++)
            op(2'($random(seed)), $random(seed) & 32'h8000_003f, ($random(seed) % 8) == 0);
        rq.valid = 1'b0;
        print_verdict;
    end
endmodule
bind excl_monitor excl_monitor_chk chk_i (.mclk(mclk), .rst_n(rst_n), .lsu_req(lsu_req), .lsu_ready(lsu_ready),
    .mem_req(mem_req), .mem_ready(mem_ready), .status_wb(status_wb), .excl_state(excl_state));
